// ===== pkg/zvsdt_pkg.sv
// Constants, bus carriers and state encoding for the ZVS tuning block
package zvsdt_pkg;

	// Bus geometry
	localparam int unsigned ADR_W = 8;
	localparam int unsigned DAT_W = 32;

	// Register byte offsets
	localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] OFS_LS_ON = 8'h04;
	localparam logic [ADR_W-1:0] OFS_TZ_MIN = 8'h08;
	localparam logic [ADR_W-1:0] OFS_STEP = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADR_W-1:0] OFS_SENSE = 8'h14;
	localparam logic [ADR_W-1:0] OFS_TIMING = 8'h18;

	// Field positions
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_RELOCK_BIT = 1;
	localparam int unsigned STAT_REJECT_BIT = 2;

	// Field widths
	localparam int unsigned CNT_W = 16;
	localparam int unsigned TDM_W = 12;
	localparam int unsigned TZ_W = 10;
	localparam int unsigned TZMIN_W = 8;
	localparam int unsigned LINE_W = 10;
	localparam int unsigned SETTLE_W = 4;

	// Values after reset, with the on-time limits and least step
	localparam logic [CNT_W-1:0] LS_ON_RST = 16'h0064;
	localparam logic [TZMIN_W-1:0] TZ_MIN_RST = 8'h04;
	localparam logic [TDM_W-1:0] STEP_RST = 12'h010;
	localparam logic [TDM_W-1:0] TDM_MIN = 12'h001;
	localparam logic [TDM_W-1:0] TDM_MAX = 12'hFFF;
	localparam logic [TDM_W-1:0] TDM_LSB = 12'h001;

	// Line feed-forward of the transition delay
	localparam logic [LINE_W-1:0] LINE_KNEE = 10'h29A;
	localparam logic [7:0] EXT_PCT = 8'h8C;
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [25:0] KNEE_X100 = 26'(LINE_KNEE) * 26'(PCT_FULL);

	// Tuning cycles allowed before lock
	localparam logic [SETTLE_W-1:0] SETTLE_LIMIT = 4'hF;

	// Wishbone request and answer
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [DAT_W-1:0] dat;
	} zvsdt_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [DAT_W-1:0] dat;
	} zvsdt_wb_rsp_t;

	// Switching cycle phases
	typedef enum logic [2:0] {
		ST_STOP,
		ST_LS_ON,
		ST_LH_DEAD,
		ST_HS_ON,
		ST_TZ,
		ST_WAIT_ZCD
	} zvsdt_state_t;

endpackage : zvsdt_pkg

// ===== hdl/zvsdt_sync.sv
// Two-stage synchroniser for pin inputs of the ZVS tuning block
`timescale 1ns/1ns
`default_nettype none

module zvsdt_sync #(
	parameter int unsigned W = 1
) (
	input wire logic core_clk,
	input wire logic rst_sync_n,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// Refuse a zero-width instance
	if (W < 1) begin : g_bad_width
		$error("zvsdt_sync width must be at least one");
	end

	// First stage feeds only the second stage
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : zvsdt_sync
`default_nettype wire

// ===== hdl/zvsdt_core.sv
// ZVS auto-tuning and dead-time control of an active-clamp flyback stage
// Operation
// - Zvs missed at the end of the transition delay raises the on-time.
// - Once locked, the on-time moves by its smallest step each cycle.
// - Starting short in valley switching, tuning settles within 15 cycles.
// - One gap is timed, high fall to low rise; low fall to high rise ends on the flag fall.
// - Line current is taken only while the low-side switch conducts.
// - Delay is minimal above 666 uA, rising linearly below to +140%.
// - A low zero-current flag at delay end blocks the low-side turn-on.
// - After a block, the next rising flag edge starts the low-side turn-on.
// - The low-to-high dead time follows the node slope for any switch type.
// - A falling zero-current flag raises the high-side gate at once; here the gate rises three clock edges later, after the two-flop synchroniser.
// - The multi-sense input gives output voltage only; line and zero-current data have their own pins.
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module zvsdt_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire zvsdt_pkg::zvsdt_wb_req_t wb_req,
	output zvsdt_pkg::zvsdt_wb_rsp_t wb_rsp,
	input wire logic switch_node_sense_input,
	input wire logic zero_current_flag,
	input wire logic [zvsdt_pkg::LINE_W-1:0] line_sense_current,
	input wire logic [zvsdt_pkg::LINE_W-1:0] multi_sense_vout,
	output logic high_side_gate_drive,
	output logic low_side_gate_drive,
	output logic tune_increase_request,
	output logic zvs_locked
);
	import zvsdt_pkg::*;

	localparam int unsigned SYNC_W = 2 + 2 * LINE_W;

	logic [1:0] rst_pipe_q;
	logic [SYNC_W-1:0] pins_s;
	logic [LINE_W-1:0] line_s, vout_s, line_q, vout_q;
	logic rst_sync_n, sws_below_s, zcd_s, zcd_prev_q, zcd_rise, zcd_fall;
	zvsdt_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, target, ls_on_q;
	logic timer_done, en_q, relock, tune_evt, tune_up, reject_evt;
	logic [TZMIN_W-1:0] tz_min_q;
	logic [TDM_W-1:0] step_q, tdm_q, step_use;
	logic [TZ_W-1:0] tz_q, tz_calc;
	logic [25:0] ext_num;
	logic dir_q, have_dir_q, locked_q, late_q, reject_q;
	logic [SETTLE_W-1:0] settle_q;
	logic hs_q, ls_q, inc_q, ack_q, bus_req, bus_wr;
	logic [DAT_W-1:0] rdat_q, wmask;

	// Reset release through two flops; async assert, clocked release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_q[1];

	// Pins come from the analog front end, so all pass two flops.
	// The line and vout codes move slowly compared to the clock; a
	// torn word is possible but lasts one sample only.
	zvsdt_sync #(
		.W(SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.clk_en(clk_en),
		.async_in({switch_node_sense_input, zero_current_flag,
			line_sense_current, multi_sense_vout}),
		.sync_out(pins_s)
	);
	assign sws_below_s = pins_s[SYNC_W-1];
	assign zcd_s = pins_s[SYNC_W-2];
	assign line_s = pins_s[2*LINE_W-1:LINE_W];
	assign vout_s = pins_s[LINE_W-1:0];

	// Zero-current flag edges, seen on the synchronised copy
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			zcd_prev_q <= 1'b0;
		end else if (clk_en) begin
			zcd_prev_q <= zcd_s;
		end
	end
	assign zcd_rise = zcd_s && !zcd_prev_q;
	assign zcd_fall = !zcd_s && zcd_prev_q;

	// Bus strobes; a write lands on the edge that sees ack high, so the
	// master's view and the register update share one edge
	assign bus_req = wb_req.cyc && wb_req.stb && !ack_q;
	assign bus_wr = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
	assign relock = bus_wr && (wb_req.adr == OFS_CTRL) &&
		wb_req.sel[0] && wb_req.dat[CTRL_RELOCK_BIT];
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{wb_req.sel[b]}};
		end
	end

	// Software controls; written at the edge that samples ack high
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			en_q <= 1'b0;
			ls_on_q <= LS_ON_RST;
			tz_min_q <= TZ_MIN_RST;
			step_q <= STEP_RST;
		end else if (clk_en && bus_wr) begin
			unique case (wb_req.adr)
				OFS_CTRL: begin
					if (wb_req.sel[0]) begin
						en_q <= wb_req.dat[CTRL_EN_BIT];
					end
				end
				OFS_LS_ON: begin
					ls_on_q <= (ls_on_q & ~wmask[CNT_W-1:0]) |
						(wb_req.dat[CNT_W-1:0] & wmask[CNT_W-1:0]);
				end
				OFS_TZ_MIN: begin
					if (wb_req.sel[0]) begin
						tz_min_q <= wb_req.dat[TZMIN_W-1:0];
					end
				end
				OFS_STEP: begin
					step_q <= (step_q & ~wmask[TDM_W-1:0]) |
						(wb_req.dat[TDM_W-1:0] & wmask[TDM_W-1:0]);
				end
				default: begin
				end
			endcase
		end
	end

	// Read data and a one-cycle ack; unmapped reads return zero
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else if (clk_en) begin
			ack_q <= bus_req;
			if (bus_req && !wb_req.we) begin
				unique case (wb_req.adr)
					OFS_CTRL: rdat_q <= DAT_W'(en_q);
					OFS_LS_ON: rdat_q <= DAT_W'(ls_on_q);
					OFS_TZ_MIN: rdat_q <= DAT_W'(tz_min_q);
					OFS_STEP: rdat_q <= DAT_W'(step_q);
					OFS_STATUS: rdat_q <= {4'h0, tdm_q, 13'h0000,
						reject_q, late_q, locked_q};
					OFS_SENSE: rdat_q <= {6'h00, vout_q, 6'h00, line_q};
					OFS_TIMING: rdat_q <= DAT_W'(tz_q);
					default: rdat_q <= '0;
				endcase
			end
		end
	end
	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	// Line current is only meaningful while the low side conducts
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			line_q <= '0;
		end else if (clk_en && st_q == ST_LS_ON) begin
			line_q <= line_s;
		end
	end

	// Output voltage reflects on the aux winding during demagnetisation
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			vout_q <= '0;
		end else if (clk_en && st_q == ST_LH_DEAD) begin
			vout_q <= vout_s;
		end
	end

	// Transition delay: minimum at high line, linear stretch below knee
	always_comb begin
		ext_num = '0;
		tz_calc = TZ_W'(tz_min_q);
		if (line_q < LINE_KNEE) begin
			ext_num = 26'(tz_min_q) * 26'(LINE_KNEE - line_q) *
				26'(EXT_PCT);
			tz_calc = TZ_W'(tz_min_q) + TZ_W'(ext_num / KNEE_X100);
		end
	end

	// Registered delay breaks the divider path from the timer compare
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tz_q <= TZ_W'(TZ_MIN_RST);
		end else if (clk_en) begin
			tz_q <= tz_calc;
		end
	end

	// One timer serves every timed phase of the cycle
	always_comb begin
		unique case (st_q)
			ST_LS_ON: target = ls_on_q;
			ST_HS_ON: target = CNT_W'(tdm_q);
			ST_TZ: target = CNT_W'(tz_q);
			default: target = '0;
		endcase
	end
	assign timer_done = ({1'b0, cnt_q} + 17'h0_0001) >= {1'b0, target};

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (st_d != st_q) begin
				cnt_q <= '0;
			end else if (cnt_q != '1) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// Cycle sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_STOP: begin
				if (en_q) begin
					st_d = ST_LS_ON;
				end
			end
			ST_LS_ON: begin
				if (timer_done) begin
					st_d = ST_LH_DEAD;
				end
			end
			ST_LH_DEAD: begin
				// Slope-adaptive, no switch-type branch at all
				if (zcd_fall) begin
					st_d = ST_HS_ON;
				end
			end
			ST_HS_ON: begin
				if (timer_done) begin
					st_d = ST_TZ;
				end
			end
			ST_TZ: begin
				// A short dip lets the flag fall back before tz ends
				if (timer_done) begin
					st_d = zcd_s ? ST_LS_ON : ST_WAIT_ZCD;
				end
			end
			ST_WAIT_ZCD: begin
				if (zcd_rise) begin
					st_d = ST_LS_ON;
				end
			end
		endcase
		if (!en_q) begin
			st_d = ST_STOP;
		end
	end

	// State and gate drives both follow the next state, so a gate
	// changes on the same edge as the phase and never overlaps
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_q <= ST_STOP;
			hs_q <= 1'b0;
			ls_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			hs_q <= (st_d == ST_HS_ON);
			ls_q <= (st_d == ST_LS_ON);
		end
	end
	assign high_side_gate_drive = hs_q;
	assign low_side_gate_drive = ls_q;

	// Discriminator verdict at the end of the transition delay
	assign tune_evt = clk_en && st_q == ST_TZ && timer_done && en_q;
	assign tune_up = !sws_below_s;
	assign reject_evt = tune_evt && !zcd_s;
	assign step_use = locked_q ? TDM_LSB : step_q;

	// On-time: restarts short, saturates at both ends
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tdm_q <= TDM_MIN;
			inc_q <= 1'b0;
		end else if (clk_en) begin
			if (st_q == ST_STOP) begin
				tdm_q <= TDM_MIN;
			end else if (tune_evt && tune_up) begin
				inc_q <= 1'b1;
				if (tdm_q > TDM_MAX - step_use) begin
					tdm_q <= TDM_MAX;
				end else begin
					tdm_q <= tdm_q + step_use;
				end
			end else if (tune_evt) begin
				inc_q <= 1'b0;
				if ({1'b0, tdm_q} < {1'b0, TDM_MIN} + {1'b0, step_use}) begin
					tdm_q <= TDM_MIN;
				end else begin
					tdm_q <= tdm_q - step_use;
				end
			end
		end
	end
	assign tune_increase_request = inc_q;

	// Lock on the first reversal of the tuning direction
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dir_q <= 1'b0;
			have_dir_q <= 1'b0;
			locked_q <= 1'b0;
		end else if (clk_en) begin
			if (relock || st_q == ST_STOP) begin
				have_dir_q <= 1'b0;
				locked_q <= 1'b0;
			end else if (tune_evt) begin
				dir_q <= tune_up;
				have_dir_q <= 1'b1;
				if (have_dir_q && dir_q != tune_up) begin
					locked_q <= 1'b1;
				end
			end
		end
	end
	assign zvs_locked = locked_q;

	// Settling watchdog; the late flag survives a same-cycle clear
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			settle_q <= '0;
			late_q <= 1'b0;
		end else if (clk_en) begin
			if (relock || st_q == ST_STOP) begin
				settle_q <= '0;
			end else if (tune_evt && !locked_q && settle_q != SETTLE_LIMIT) begin
				settle_q <= settle_q + 4'h1;
			end
			// Set on the limit-reaching event only, so relock can clear it
			if (tune_evt && !locked_q && settle_q == SETTLE_LIMIT - 4'h1) begin
				late_q <= 1'b1;
			end else if (relock) begin
				late_q <= 1'b0;
			end
		end
	end

	// Sticky record of a blocked low-side turn-on, write one to clear
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reject_q <= 1'b0;
		end else if (clk_en) begin
			if (reject_evt) begin
				reject_q <= 1'b1;
			end else if (bus_wr && wb_req.adr == OFS_STATUS &&
				wb_req.sel[0] && wb_req.dat[STAT_REJECT_BIT]) begin
				reject_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_tz_end;
		clk_en && en_q && st_q == ST_TZ && timer_done;
	endsequence

	AST_TUNE_UP: assert property (s_tz_end and !sws_below_s |=>
		inc_q && (tdm_q > $past(tdm_q) || tdm_q == TDM_MAX))
		else $error("on-time not raised after missed zvs");
	AST_LSB_STEP: assert property (s_tz_end and locked_q |=>
		(tdm_q - $past(tdm_q) == TDM_LSB) ||
		($past(tdm_q) - tdm_q == TDM_LSB) || tdm_q == TDM_MIN ||
		tdm_q == TDM_MAX)
		else $error("locked on-time moved by more than one step");
	AST_SETTLE: assert property (s_tz_end and
		(!locked_q && settle_q == SETTLE_LIMIT - 4'h1) |=> late_q)
		else $error("settling watchdog missed its limit");
	AST_NO_OVERLAP: assert property (!(hs_q && ls_q))
		else $error("both gate drives high");
	AST_LINE_SAMPLE: assert property ($changed(line_q) |->
		$past(st_q) == ST_LS_ON)
		else $error("line current sampled outside low-side conduction");
	AST_TZ_KNEE: assert property ((line_q >= LINE_KNEE) |->
		tz_calc == TZ_W'(tz_min_q))
		else $error("transition delay stretched above knee");
	AST_TZ_RANGE: assert property ((tz_calc >= TZ_W'(tz_min_q)) and
		(line_q == '0 |-> tz_calc == TZ_W'(tz_min_q) +
		TZ_W'((26'(tz_min_q) * 26'(EXT_PCT)) / 26'(PCT_FULL))))
		else $error("transition delay outside its range");
	AST_REJECT: assert property (s_tz_end and !zcd_s |=>
		st_q == ST_WAIT_ZCD && !ls_q && reject_q)
		else $error("low side turned on without valid transition");
	AST_WAIT_RISE: assert property (clk_en && en_q &&
		st_q == ST_WAIT_ZCD && zcd_rise |=> ls_q)
		else $error("rising flag did not start low-side turn-on");
	AST_HS_NOW: assert property (clk_en && en_q &&
		st_q == ST_LH_DEAD && zcd_fall |=> hs_q && !ls_q)
		else $error("high side not driven on falling flag");
	AST_SAT: assert property (tdm_q >= TDM_MIN &&
		!(clk_en && $past(tdm_q) == TDM_MAX && tdm_q == TDM_MIN &&
		$past(st_q) != ST_STOP))
		else $error("on-time wrapped around");

endmodule : zvsdt_core
`default_nettype wire

// ===== tb/zvsdt_stage_model.sv
// Behavioural flyback power stage answering the two gate drives
`timescale 1ns/1ns
`default_nettype none

module zvsdt_stage_model (
	input wire logic core_clk,
	input wire logic hs,
	input wire logic ls,
	input wire logic [12:0] need,
	input wire logic late,
	input wire logic [9:0] line_val,
	input wire logic [9:0] vout_val,
	output logic sense,
	output logic flag,
	output logic [9:0] line,
	output logic [9:0] vout
);
	logic hs_q, ls_q;
	logic [12:0] on_cnt;
	logic [4:0] rise_cnt, fall_cnt;

	initial begin
		{sense, flag, hs_q, ls_q, on_cnt, rise_cnt, fall_cnt} = '0;
	end

	// Node swing: ZVS is seen only when the on-time built enough current
	always @(posedge core_clk) begin
		hs_q <= hs;
		ls_q <= ls;
		on_cnt <= hs ? on_cnt + 13'h0001 : 13'h0000;
		if (hs && !hs_q)
			sense <= 1'b0;
		if (!hs && hs_q) begin
			sense <= (on_cnt >= need);
			flag <= !late;
			rise_cnt <= late ? 5'h14 : 5'h00;
		end else if (rise_cnt != 5'h00) begin
			rise_cnt <= rise_cnt - 5'h01;
			if (rise_cnt == 5'h01)
				flag <= 1'b1;
		end
		// Flag falls shortly after the low side releases the node
		if (ls && !ls_q)
			flag <= 1'b1;
		if (!ls && ls_q) begin
			fall_cnt <= 5'h02;
		end else if (fall_cnt != 5'h00) begin
			fall_cnt <= fall_cnt - 5'h01;
			if (fall_cnt == 5'h01)
				flag <= 1'b0;
		end
		// Line current is only meaningful while the low side conducts
		line <= ls ? line_val : ~line_val;
		vout <= vout_val;
	end
endmodule : zvsdt_stage_model

`default_nettype wire

// ===== tb/zvs_tuning_deadtime_control_tb.sv
// Self-checking bench for the ZVS tuning and dead-time block
`timescale 1ns/1ns
`default_nettype none

module zvs_tuning_deadtime_control_tb;
	import zvsdt_pkg::*;

	logic core_clk, rst_n, sense, flag, hs, ls, inc, locked, late;
	zvsdt_wb_req_t req;
	zvsdt_wb_rsp_t rsp;
	logic [9:0] line, vout, line_val, vout_val;
	logic [12:0] need;
	logic [31:0] rd;
	int error_cnt, n_tests;
	int w [20];

	zvsdt_core u_zvsdt_core (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(1'b1), .wb_req(req), .wb_rsp(rsp),
		.switch_node_sense_input(sense), .zero_current_flag(flag),
		.line_sense_current(line), .multi_sense_vout(vout),
		.high_side_gate_drive(hs), .low_side_gate_drive(ls),
		.tune_increase_request(inc), .zvs_locked(locked));

	zvsdt_stage_model u_zvsdt_stage_model (.core_clk(core_clk),
		.hs(hs), .ls(ls), .need(need), .late(late),
		.line_val(line_val), .vout_val(vout_val), .sense(sense),
		.flag(flag), .line(line), .vout(vout));

	task automatic tick;
		@(posedge core_clk);
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	function automatic logic pick(input int s);
		return (s == 0) ? hs : (s == 1) ? ls : flag;
	endfunction : pick

	// Count edges until a gate or the flag reaches a level, bounded
	task automatic wait_sig(input int s, input logic lvl, output int n);
		n = 0;
		while (pick(s) !== lvl && n < 9000) begin
			tick;
			n++;
		end
		if (n >= 9000)
			chk(32'h0000_0000, 32'h0000_0001, "wait timeout");
	endtask : wait_sig

	task automatic hs_width(output int wd);
		int n;
		wait_sig(0, 1'b1, n);
		wait_sig(0, 1'b0, wd);
	endtask : hs_width

	// Classic single Wishbone cycle; entered just after a rising edge
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		tick;
		while (rsp.ack !== 1'b1 && n < 50) begin
			tick;
			n++;
		end
		rd = rsp.dat;
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001, "no ack");
		req <= '0;
		tick;
	endtask : wb

	task automatic start(input logic [11:0] step, input logic [12:0] nd);
		wb(1'b1, OFS_CTRL, 32'h0000_0000);
		need <= nd;
		wb(1'b1, OFS_TZ_MIN, 32'(TZ_MIN_RST));
		wb(1'b1, OFS_STEP, {20'h0_0000, step});
		wb(1'b1, OFS_LS_ON, 32'h0000_0008);
		wb(1'b1, OFS_CTRL, 32'h0000_0001);
	endtask : start

	task automatic t_reset;
		wb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "ctrl reset");
		wb(1'b0, OFS_LS_ON, 32'h0000_0000);
		chk(rd, 32'(LS_ON_RST), "ls_on reset");
		wb(1'b0, OFS_TZ_MIN, 32'h0000_0000);
		chk(rd, 32'(TZ_MIN_RST), "tz_min reset");
		wb(1'b0, OFS_STEP, 32'h0000_0000);
		chk(rd, 32'(STEP_RST), "step reset");
		wb(1'b0, 8'hFC, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped read");
	endtask : t_reset

	// Coarse climb from a short on-time, then LSB toggling near target
	task automatic t_lock;
		int n;
		start(12'h010, 13'h0028);
		for (int i = 0; i < 20; i++) begin
			hs_width(w[i]);
			wait_sig(1, 1'b1, n);
			tick;
			chk(inc, w[i] < 40, "increase request");
		end
		chk(w[0], 32'h0000_0001, "short start");
		chk(locked, 1'b1, "locked");
		for (int i = 15; i < 20; i++) begin
			chk(w[i], w[i-2], "toggle");
			chk(w[i] + w[i-1], 79, "lsb step");
		end
	endtask : t_lock

	// Both ends of the on-time range hold instead of wrapping
	task automatic t_sat;
		start(12'h800, 13'h1FFF);
		for (int i = 0; i < 4; i++)
			hs_width(w[i]);
		chk(w[1], 2049, "climb");
		chk(w[2], 4095, "top");
		chk(w[3], 4095, "top held");
		start(12'h010, 13'h0000);
		for (int i = 0; i < 16; i++)
			hs_width(w[i]);
		chk(w[2], 1, "bottom held");
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd[1:0], 2'b10, "late without lock");
		wb(1'b1, OFS_CTRL, 32'h0000_0003);
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd[1:0], 2'b00, "late cleared by relock");
	endtask : t_sat

	// Transition delay against line current, timed at the gates
	task automatic t_tz;
		int tm [4] = '{4, 4, 100, 100};
		int ln [4] = '{766, 0, 333, 665};
		int n, ex;
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, OFS_CTRL, 32'h0000_0000);
			line_val <= ln[i][9:0];
			wb(1'b1, OFS_TZ_MIN, tm[i]);
			wb(1'b1, OFS_CTRL, 32'h0000_0001);
			hs_width(n);
			hs_width(n);
			ex = tm[i];
			if (ln[i] < 666)
				ex += tm[i] * (666 - ln[i]) * 140 / 66600;
			wait_sig(1, 1'b1, n);
			chk(n, ex, "hs fall to ls rise");
			wb(1'b0, OFS_TIMING, 32'h0000_0000);
			chk(rd[9:0], ex, "timing reg");
			wb(1'b0, OFS_SENSE, 32'h0000_0000);
			chk(rd, {6'h00, vout_val, 6'h00, ln[i][9:0]}, "sense");
		end
	endtask : t_tz

	// Prompt high side on flag fall; late flag blocks the low side
	task automatic t_reject;
		int n;
		start(12'h010, 13'h0000);
		wait_sig(1, 1'b1, n);
		wait_sig(2, 1'b1, n);
		wait_sig(2, 1'b0, n);
		wait_sig(0, 1'b1, n);
		chk(n, 3, "flag fall to hs rise");
		hs_width(n);
		late <= 1'b1;
		hs_width(n);
		wait_sig(1, 1'b1, n);
		chk(n > 20 && n < 30, 1'b1, "ls held off");
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd[STAT_REJECT_BIT], 1'b1, "reject flag");
		late <= 1'b0;
		hs_width(n);
		wait_sig(1, 1'b1, n);
		chk(n, 4, "normal again");
		wb(1'b1, OFS_STATUS, 32'h0000_0004);
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd[STAT_REJECT_BIT], 1'b0, "reject cleared");
	endtask : t_reject

	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Gates must never conduct together
	always @(posedge core_clk) begin
		if (hs === 1'b1 && ls === 1'b1)
			chk(32'h0000_0001, 32'h0000_0000, "gates overlap");
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		req = '0;
		need = '0;
		late = 1'b0;
		line_val = 10'h3FF;
		vout_val = 10'h155;
		error_cnt = 0;
		n_tests = 0;
		repeat (3) tick;
		rst_n <= 1'b1;
		repeat (3) tick;
		t_reset;
		t_lock;
		t_sat;
		t_tz;
		t_reject;
		print_verdict;
	end

	// Watchdog well beyond the expected run length
	initial begin
		#(90000 * 50);
		error_cnt++;
		print_verdict;
	end
endmodule : zvs_tuning_deadtime_control_tb

`default_nettype wire
